// file: sarac_top.sv
// Control, timing and result logic of the eight-channel converter
`timescale 1ns/1ps
module sarac_top (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Processor register port
	input  wire logic [15:0] ADDR,        // Byte address
	input  wire logic        WR_BYTE,     // Byte write strobe
	input  wire logic        WR_BIT,      // Single-bit write strobe
	input  wire logic [2:0]  BIT_SEL,     // Bit number for bit write
	input  wire logic [7:0]  WDATA,       // Write data, bit 0 for bit write
	input  wire logic        RD,          // Read strobe
	output logic      [15:0] RDATA,       // Read data
	// Analog front end
	input  wire logic        COMP_IN,     // Comparator: input at or above tap
	output logic      [2:0]  CHAN_SEL,    // Channel to the multiplexer
	output logic      [9:0]  TAP_CODE,    // Trial code to the ladder
	output logic             SAMPLE,      // Sample and hold in sample phase
	// Trigger and events
	input  wire logic        EXT_CONV_TRIGGER, // External trigger pin
	output logic             CONV_DONE_IRQ     // Completion pulse
);
	typedef enum {ST_IDLE, ST_WAIT_TRIG, ST_SAMPLE, ST_CONVERT} sarac_state_t;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  conv_mode_reg;    // Mode register
	logic [2:0]  chan_select_reg;  // Channel select register
	logic [9:0]  approx_register;  // Approximation register
	logic [9:0]  conv_result_reg;  // Result, upper ten bits
	logic [3:0]  bit_idx_reg;      // Bit under trial
	sarac_state_t state_reg;       // Sequencer state
	logic [2:0]  trig_sync_reg;    // Trigger synchroniser and history
	logic        done_reg;         // Completion pulse
	logic [15:0] rdata_reg;        // Read data

	// Decoded control
	logic        conv_enable_bit;
	logic        trigger_source_bit;
	logic [2:0]  conv_time_sel;
	logic [1:0]  trig_edge_sel;
	logic        mode_wr, chan_wr, reg_wr;
	logic [7:0]  mode_next;
	logic [7:0]  step_period;
	logic        step;
	logic        rise, fall, trig_hit;

	assign conv_enable_bit    = conv_mode_reg[sarac_pkg::ENABLE_BIT];
	assign trigger_source_bit = conv_mode_reg[sarac_pkg::TRIG_SRC_BIT];
	assign conv_time_sel      = conv_mode_reg[sarac_pkg::TIME_HI:sarac_pkg::TIME_LO];
	assign trig_edge_sel      = conv_mode_reg[sarac_pkg::EDGE_HI:sarac_pkg::EDGE_LO];

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	assign mode_wr = (WR_BYTE || WR_BIT) && (ADDR == sarac_pkg::MODE_ADDR);
	assign chan_wr = WR_BYTE && (ADDR == sarac_pkg::CHAN_ADDR);
	assign reg_wr  = mode_wr || chan_wr;

	// Bit write changes one bit, byte write all; bit 0 forced zero
	always_comb begin
		mode_next = conv_mode_reg;
		if (WR_BYTE) begin
			mode_next = WDATA;
		end else if (WR_BIT) begin
			mode_next[BIT_SEL] = WDATA[0];
		end
		mode_next = mode_next & sarac_pkg::MODE_WMASK;
	end

	// Mode register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			conv_mode_reg <= sarac_pkg::MODE_RESET;
		end else if (mode_wr) begin
			conv_mode_reg <= mode_next;
		end
	end

	// Channel register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			chan_select_reg <= sarac_pkg::CHAN_RESET;
		end else if (chan_wr) begin
			chan_select_reg <= WDATA[2:0];
		end
	end

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	// Twelve steps per conversion: two sampling, ten bit trials.
	// Prohibited codes fall back to the slowest time, the safe choice.
	always_comb begin
		case (conv_time_sel)
			3'h0:    step_period = sarac_pkg::TIME_144 / sarac_pkg::STEP_DIV;
			3'h1:    step_period = sarac_pkg::TIME_120 / sarac_pkg::STEP_DIV;
			3'h2:    step_period = sarac_pkg::TIME_96  / sarac_pkg::STEP_DIV;
			3'h4:    step_period = sarac_pkg::TIME_72  / sarac_pkg::STEP_DIV;
			3'h5:    step_period = sarac_pkg::TIME_60  / sarac_pkg::STEP_DIV;
			3'h6:    step_period = sarac_pkg::TIME_48  / sarac_pkg::STEP_DIV;
			default: step_period = sarac_pkg::TIME_144 / sarac_pkg::STEP_DIV;
		endcase
	end

	sarac_step_div #(.W(8)) u_div (
		.clk    (CLK),
		.rst    (RST),
		.clear  (reg_wr || state_reg == ST_IDLE || state_reg == ST_WAIT_TRIG),
		.period (step_period),
		.step   (step)
	);

	// ----------------------------------------
	// External trigger
	// ----------------------------------------
	// Two flops then one of history; edges judged on the synced pair only
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			trig_sync_reg <= 3'h0;
		end else begin
			trig_sync_reg <= {trig_sync_reg[1:0], EXT_CONV_TRIGGER};
		end
	end

	assign rise     = trig_sync_reg[1] && !trig_sync_reg[2];
	assign fall     = !trig_sync_reg[1] && trig_sync_reg[2];
	assign trig_hit = (trig_edge_sel[1] && rise) || (trig_edge_sel[0] && fall);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg   <= ST_IDLE;
			bit_idx_reg <= 4'h0;
		end else if (reg_wr) begin
			// Abort; new settings take effect next cycle
			state_reg   <= ST_IDLE;
			bit_idx_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (conv_enable_bit) begin
						state_reg <= trigger_source_bit ? ST_WAIT_TRIG : ST_SAMPLE;
					end
				end
				ST_WAIT_TRIG: begin
					if (!conv_enable_bit) begin
						state_reg <= ST_IDLE;
					end else if (trig_hit) begin
						state_reg   <= ST_SAMPLE;
						bit_idx_reg <= 4'h0;
					end
				end
				ST_SAMPLE: begin
					if (step) begin
						if (bit_idx_reg == 4'h1) begin
							state_reg   <= ST_CONVERT;
							bit_idx_reg <= 4'(sarac_pkg::RES_BITS - 1);
						end else begin
							bit_idx_reg <= bit_idx_reg + 4'h1;
						end
					end
				end
				ST_CONVERT: begin
					if (step && bit_idx_reg == 4'h0) begin
						// Restart at once in software mode, else wait
						state_reg <= trigger_source_bit ? ST_WAIT_TRIG : ST_SAMPLE;
					end else if (step) begin
						bit_idx_reg <= bit_idx_reg - 4'h1;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Approximation register
	// ----------------------------------------
	// Trial bit set at slice start, kept or dropped at slice end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			approx_register <= 10'h000;
		end else if (state_reg == ST_SAMPLE && step && bit_idx_reg == 4'h1) begin
			approx_register <= 10'h200;
		end else if (state_reg == ST_CONVERT && step) begin
			approx_register[bit_idx_reg] <= COMP_IN;
			if (bit_idx_reg != 4'h0) begin
				approx_register[bit_idx_reg - 4'h1] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Result and completion
	// ----------------------------------------
	// No reset: contents are undefined until the first conversion
	always_ff @(posedge CLK) begin
		if (state_reg == ST_CONVERT && step && bit_idx_reg == 4'h0 && !reg_wr) begin
			conv_result_reg <= {approx_register[9:1], COMP_IN};
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= state_reg == ST_CONVERT && step && bit_idx_reg == 4'h0 && !reg_wr;
		end
	end
	assign CONV_DONE_IRQ = done_reg;

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_reg <= 16'h0000;
		end else if (RD) begin
			if (ADDR == sarac_pkg::RESULT_ADDR_LO) begin
				rdata_reg <= {conv_result_reg, {sarac_pkg::PAD_BITS{1'b0}}};
			end else if (ADDR == sarac_pkg::MODE_ADDR) begin
				rdata_reg <= {8'h00, conv_mode_reg};
			end else if (ADDR == sarac_pkg::CHAN_ADDR) begin
				rdata_reg <= {13'h0000, chan_select_reg};
			end else begin
				rdata_reg <= 16'h0000;
			end
		end
	end
	assign RDATA = rdata_reg;

	// Analog front end drive
	assign CHAN_SEL = chan_select_reg;
	assign TAP_CODE = approx_register;
	assign SAMPLE   = state_reg == ST_SAMPLE;
endmodule // sarac_top

// file: sarac_pkg.sv
// Package of constants for the successive-approximation converter control block
package sarac_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [15:0] RESULT_ADDR_LO = 16'hff18; // Result, low byte
	localparam logic [15:0] MODE_ADDR      = 16'hff80; // Mode register
	localparam logic [15:0] CHAN_ADDR      = 16'hff81; // Channel select
	// ----------------------------------------
	// Mode register fields
	// ----------------------------------------
	localparam int          ENABLE_BIT   = 7;     // Conversion enable
	localparam int          TRIG_SRC_BIT = 6;     // 1 = external trigger
	localparam int          TIME_HI      = 5;     // Conversion time field top
	localparam int          TIME_LO      = 3;     // Conversion time field bottom
	localparam int          EDGE_HI      = 2;     // Edge field top
	localparam int          EDGE_LO      = 1;     // Edge field bottom
	localparam logic [7:0]  MODE_RESET   = 8'h00; // Mode reset value
	localparam logic [7:0]  MODE_WMASK   = 8'hfe; // Bit 0 fixed zero
	localparam logic [2:0]  CHAN_RESET   = 3'h0;  // Channel reset value
	// ----------------------------------------
	// Resolution and result layout
	// ----------------------------------------
	localparam int          RES_BITS     = 10;    // Converter resolution
	localparam int          PAD_BITS     = 6;     // Zero bits below result
	localparam int          CHANNELS     = 8;     // Analog channels
	// ----------------------------------------
	// Conversion times in system clock periods
	// ----------------------------------------
	localparam logic [7:0]  TIME_144 = 8'h90;     // Code 000
	localparam logic [7:0]  TIME_120 = 8'h78;     // Code 001
	localparam logic [7:0]  TIME_96  = 8'h60;     // Code 010
	localparam logic [7:0]  TIME_72  = 8'h48;     // Code 100
	localparam logic [7:0]  TIME_60  = 8'h3c;     // Code 101
	localparam logic [7:0]  TIME_48  = 8'h30;     // Code 110
	localparam logic [7:0]  STEP_DIV = 8'h0c;     // Clock periods split into 12 steps
endpackage

// file: sarac_step_div.sv
// Divider giving one step enable per conversion-time slice
`timescale 1ns/1ps
module sarac_step_div #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Control
	input  wire logic         clear,   // Restart the slice count
	input  wire logic [W-1:0] period,  // Cycles per step
	// Output
	output logic              step     // One-cycle pulse
);
	// Elaboration check: a narrow count cannot hold the slowest slice
	if (W < 4) begin : g_width_check
		$error("sarac_step_div: width too small");
	end

	logic [W-1:0] cnt_reg; // Cycles elapsed in this slice

	// ----------------------------------------
	// Slice counter
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (clear || step) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Pulse on the last cycle of a slice
	assign step = !clear && (cnt_reg == period - 1'b1);
endmodule // sarac_step_div

// file: sarac_chk.sv
// Checker for the converter control block ports
`timescale 1ns/1ps
module sarac_chk (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RST,
	// Register port
	input wire logic [15:0] ADDR,
	input wire logic        WR_BYTE,
	input wire logic        WR_BIT,
	input wire logic [2:0]  BIT_SEL,
	input wire logic [7:0]  WDATA,
	input wire logic        RD,
	input wire logic [15:0] RDATA,
	// Converter side
	input wire logic [2:0]  CHAN_SEL,
	input wire logic        CONV_DONE_IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ----
	// Helper logic
	// ----
	logic       wr;       // Register write that aborts a conversion
	logic [7:0] mode_reg; // Shadow of the mode register
	logic [8:0] gap_reg;  // Cycles since last completion or write
	logic [8:0] t_len;    // Conversion time of the shadow setting
	// Writes elsewhere leave the sequencer running, so they must not reset the gap
	assign wr = ((WR_BYTE || WR_BIT) && ADDR == sarac_pkg::MODE_ADDR)
		|| (WR_BYTE && ADDR == sarac_pkg::CHAN_ADDR);
	// Mode shadow, bit 0 kept clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			mode_reg <= 8'h00;
		else if (WR_BYTE && ADDR == sarac_pkg::MODE_ADDR)
			mode_reg <= WDATA & sarac_pkg::MODE_WMASK;
		else if (WR_BIT && ADDR == sarac_pkg::MODE_ADDR && BIT_SEL != 3'h0)
			mode_reg[BIT_SEL] <= WDATA[0];
	end
	// Gap counter, saturating so it never wraps
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			gap_reg <= 9'h000;
		else if (CONV_DONE_IRQ || wr)
			gap_reg <= 9'h000;
		else if (gap_reg != 9'h1ff)
			gap_reg <= gap_reg + 9'h001;
	end
	// Prohibited codes run as the slowest
	always_comb begin
		case (mode_reg[5:3])
			3'h1: t_len = 9'h078;
			3'h2: t_len = 9'h060;
			3'h4: t_len = 9'h048;
			3'h5: t_len = 9'h03c;
			3'h6: t_len = 9'h030;
			default: t_len = 9'h090;
		endcase
	end
	// ----
	// Assertions
	// ----
	a_irq_pulse: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
		else $error("completion pulse longer than one cycle");
	a_stop_quiet: assert property (!mode_reg[7] && !$past(mode_reg[7]) |-> !CONV_DONE_IRQ)
		else $error("completion while stopped");
	a_edge_none: assert property (mode_reg[7:6] == 2'b11 && mode_reg[2:1] == 2'b00
		&& $past(mode_reg) == mode_reg |-> !CONV_DONE_IRQ)
		else $error("conversion with no edge selected");
	a_period_min: assert property (CONV_DONE_IRQ |-> gap_reg >= t_len - 9'h002)
		else $error("conversion shorter than its setting");
	a_period_max: assert property (mode_reg[7:6] == 2'b10 |-> gap_reg <= t_len + 9'h004)
		else $error("repeat conversion missing");
	a_mode_read: assert property (RD && ADDR == sarac_pkg::MODE_ADDR && !wr
		|=> RDATA == {8'h00, $past(mode_reg)})
		else $error("mode readback wrong");
	a_result_pad: assert property (RD && ADDR == sarac_pkg::RESULT_ADDR_LO
		|=> RDATA[5:0] == 6'h00)
		else $error("result low bits not zero");
	a_unmapped_zero: assert property (RD && ADDR != sarac_pkg::MODE_ADDR
		&& ADDR != sarac_pkg::CHAN_ADDR && ADDR != sarac_pkg::RESULT_ADDR_LO
		|=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!RD |=> $stable(RDATA))
		else $error("read data moved without a read");
	a_chan_follow: assert property (WR_BYTE && ADDR == sarac_pkg::CHAN_ADDR
		|=> CHAN_SEL == $past(WDATA[2:0]))
		else $error("channel select not updated");
endmodule // sarac_chk

bind sarac_top sarac_chk i_chk (
	.CLK(CLK), .RST(RST), .ADDR(ADDR), .WR_BYTE(WR_BYTE), .WR_BIT(WR_BIT),
	.BIT_SEL(BIT_SEL), .WDATA(WDATA), .RD(RD), .RDATA(RDATA),
	.CHAN_SEL(CHAN_SEL), .CONV_DONE_IRQ(CONV_DONE_IRQ)
);

// file: sarac_afe.sv
// Analog front end model: channel levels, hold and comparator
`timescale 1ns/1ps
module sarac_afe (
	// Clock
	input wire logic       clk,
	// From the block
	input wire logic [2:0] chan_sel,
	input wire logic [9:0] tap_code,
	input wire logic       sample,
	// To the block
	output logic           comp_in
);
	logic [9:0] held_reg; // Held input as a code
	// Track the channel while sampling, hold afterwards
	always_ff @(posedge clk) begin
		if (sample)
			held_reg <= {chan_sel, 7'h00} + 10'h02d;
	end
	// Input at or above the trial tap
	assign comp_in = (held_reg >= tap_code);
endmodule // sarac_afe

// file: sarac_top_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sarac_top_bench;
	logic        CLK, RST, WR_BYTE, WR_BIT, RD, TRIG, IRQ, SAMPLE, CMP;
	logic [15:0] ADDR, RDATA;
	logic [7:0]  WDATA;
	logic [2:0]  BIT_SEL, CHAN;
	logic [9:0]  TAP;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cyc = 0;
	sarac_top i_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WR_BYTE(WR_BYTE),
		.WR_BIT(WR_BIT), .BIT_SEL(BIT_SEL), .WDATA(WDATA), .RD(RD), .RDATA(RDATA),
		.COMP_IN(CMP), .CHAN_SEL(CHAN), .TAP_CODE(TAP), .SAMPLE(SAMPLE),
		.EXT_CONV_TRIGGER(TRIG), .CONV_DONE_IRQ(IRQ));
	sarac_afe i_afe (.clk(CLK), .chan_sel(CHAN), .tap_code(TAP), .sample(SAMPLE),
		.comp_in(CMP));
	// 40 MHz clock
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	// Hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 32'h00004e20) begin
			num_errors++;
			close_out();
		end
	end
	// ----
	// Helpers
	// ----
	function automatic logic [9:0] lvl(input int c);
		return {3'(c), 7'h00} + 10'h02d;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		ADDR = a;
		WDATA = d;
		WR_BYTE = 1'b1;
		@(negedge CLK) WR_BYTE = 1'b0;
		// Idle cycle, so a following call never re-raises the strobe at once
		@(negedge CLK);
	endtask
	task automatic wbit(input logic [2:0] s, input logic v);
		ADDR = sarac_pkg::MODE_ADDR;
		BIT_SEL = s;
		WDATA = {7'h00, v};
		WR_BIT = 1'b1;
		@(negedge CLK) WR_BIT = 1'b0;
		@(negedge CLK);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		ADDR = a;
		RD = 1'b1;
		@(negedge CLK) RD = 1'b0;
		d = RDATA;
		@(negedge CLK);
	endtask
	// Cycles up to the next completion pulse, n if none
	task automatic wirq(input int n, output int k);
		k = 0;
		do begin
			@(negedge CLK);
			k++;
		end while (IRQ !== 1'b1 && k < n);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		logic [15:0] d;
		rd(sarac_pkg::MODE_ADDR, d);
		check(d, 16'h0000);
		wr(sarac_pkg::MODE_ADDR, 8'h7f);
		rd(sarac_pkg::MODE_ADDR, d);
		check(d, 16'h007e);
		wbit(3'h4, 1'b0);
		wbit(3'h0, 1'b1);
		rd(sarac_pkg::MODE_ADDR, d);
		check(d, 16'h006e);
		rd(16'hff19, d);
		check(d, 16'h0000);
		wr(sarac_pkg::MODE_ADDR, 8'h00);
	endtask
	task automatic t_sw();
		logic [15:0] d;
		int k;
		for (int c = 0; c < 8; c += 3) begin
			wr(sarac_pkg::CHAN_ADDR, 8'(c));
			wbit(3'h7, 1'b1);
			// No port input reads are issued while converting
			wirq(400, k);
			wirq(400, k);
			rd(sarac_pkg::RESULT_ADDR_LO, d);
			check(d, {lvl(c), 6'h00});
			wr(sarac_pkg::MODE_ADDR, 8'h00);
			wirq(300, k);
			check(16'(k), 16'h012c);
		end
	endtask
	task automatic t_times();
		logic [2:0] code [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
		logic [7:0] len [8] = '{8'h90, 8'h78, 8'h60, 8'h48, 8'h3c, 8'h30, 8'h90, 8'h90};
		int k;
		for (int i = 0; i < 8; i++) begin
			wr(sarac_pkg::MODE_ADDR, 8'h00);
			wr(sarac_pkg::MODE_ADDR, {2'b10, code[i], 3'h0});
			wirq(400, k);
			wirq(400, k);
			check(16'(k), 16'(len[i]));
		end
		wr(sarac_pkg::MODE_ADDR, 8'h00);
	endtask
	task automatic t_abort();
		logic [15:0] d;
		int k;
		wr(sarac_pkg::MODE_ADDR, 8'h80);
		repeat (60) @(negedge CLK);
		wr(sarac_pkg::CHAN_ADDR, 8'h05);
		wirq(400, k);
		// Full restart: idle cycle, 144 cycles, pulse; far later than the aborted run
		check(16'(k), 16'h0090);
		rd(sarac_pkg::RESULT_ADDR_LO, d);
		check(d, {lvl(5), 6'h00});
		wr(sarac_pkg::MODE_ADDR, 8'h00);
	endtask
	task automatic t_hw();
		int k;
		for (int e = 0; e < 4; e++) begin
			wr(sarac_pkg::MODE_ADDR, {5'h18, 2'(e), 1'b0});
			TRIG = 1'b1;
			wirq(300, k);
			check(16'(k != 300), 16'(e[1]));
			TRIG = 1'b0;
			wirq(300, k);
			check(16'(k != 300), 16'(e[0]));
		end
		wr(sarac_pkg::MODE_ADDR, 8'h00);
	endtask
	// Verdict and end of run
	task automatic close_out();
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		{RST, WR_BYTE, WR_BIT, RD, TRIG} = 5'h10;
		{ADDR, WDATA, BIT_SEL} = 27'h0000000;
		repeat (16) @(negedge CLK);
		RST = 1'b0;
		@(negedge CLK);
		t_regs();
		t_sw();
		t_times();
		t_abort();
		t_hw();
		close_out();
	end
endmodule // sarac_top_bench
